// file: common/mcul_defines.vh
`ifndef MCUL_DEFINES_VH
`define MCUL_DEFINES_VH

// model register address of the load trigger
`define MCUL_TRIG_ADDR 32'h0000_0079
// update data starts this many bytes past the header
`define MCUL_DATA_OFS 64'h0000_0000_0000_0030
// header word indices
`define MCUL_IDX_VERSION 30'h0000_0000
`define MCUL_IDX_DATA_SIZE 30'h0000_0008
`define MCUL_IDX_TOTAL_SIZE 30'h0000_0009
// header version this checker understands
`define MCUL_HDR_VERSION 32'h0000_0001
// word count when data size is zero
`define MCUL_DEFAULT_WORDS 30'h0000_0200
// a valid image sums to this
`define MCUL_SUM_GOOD 32'h0000_0000
// low address bits that must be zero for 16-byte alignment
`define MCUL_ALIGN_BITS 4
// reset values
`define MCUL_RST_ADDR 64'h0000_0000_0000_0000
`define MCUL_RST_SUM 32'h0000_0000
`define MCUL_RST_IDX 30'h0000_0000

`endif

// file: src/mcul_loader.v
// Contract
// RULE1 - add all image dwords modulo 2^32; image valid only if sum is zero
// RULE2 - nonzero sum means corrupt image; loader should not load it
// RULE3 - every dword is added as an unsigned 32-bit value
// RULE4 - for header version one the sum covers the whole update
// RULE5 - zero data size means 2000-byte payload and a 512-dword sum
// RULE6 - nonzero data size means total size over four dwords
// RULE7 - model register write to 79h triggers a load from the data address
// RULE8 - loader puts low address bits in low word, high bits in high word
// RULE9 - trigger address points at update data, 48 bytes past header start
// RULE10 - update data sits on a 16-byte aligned reachable address
// RULE11 - update size is a whole number of kilobytes
// RULE12 - in real mode data stays inside one segment and its limit
// RULE13 - with paging all pages of the data are present
// RULE14 - hard reset drops the loaded update
// RULE15 - soft init keeps the loaded update
// RULE16 - repeated loads of one update act as a single load
// RULE17 - firmware reloads after every hard reset during self test
// RULE18 - each core has its own update facility
// RULE19 - any thread may load; loads to one core are serialised; the loader refuses a trigger during a running check and sets collide_q
// RULE20 - load sequence follows loader revision one
// RULE21 - each processor gets an update matching its signature
// RULE22 - done pulse after the last word, pass only when sum is zero
// RULE23 - misaligned or failing image keeps old update and raises error
`timescale 1ns/100ps
`default_nettype none
`include "mcul_defines.vh"

module mcul_loader #(
    parameter ADDR_W = 64,
    parameter CNT_W = 30
) (
    // clock, reset, enable
    input wire clock,
    input wire resetn,
    input wire ce,
    // soft initialisation event
    input wire init_event,
    // model register write port
    input wire model_register_write,
    input wire [31:0] msr_addr,
    input wire [63:0] msr_wdata,
    // image memory read port
    output reg mem_req_q,
    output reg [ADDR_W-1:0] mem_addr_q,
    input wire mem_valid,
    input wire [31:0] mem_rdata,
    // check results
    output reg busy_q,
    output reg chk_done_q,
    output reg chk_pass_q,
    output reg load_err_q,
    output reg collide_q,
    // applied update
    output reg update_active_q, // RULE18
    output reg update_apply_q,
    output reg [ADDR_W-1:0] update_addr_q
);

    // one-hot states
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_REQ = 4'b0010;
    localparam [3:0] ST_WAIT = 4'b0100;
    localparam [3:0] ST_END = 4'b1000;

    reg [3:0] state_q;
    reg [3:0] state_d;
    reg [ADDR_W-1:0] base_q;
    reg [ADDR_W-1:0] data_addr_q;
    reg [CNT_W-1:0] idx_q;
    reg [CNT_W-1:0] words_q;
    reg [31:0] sum_q;
    reg [31:0] dsize_q;
    reg ver_ok_q;

    wire trig_hit;
    wire aligned;
    wire [31:0] sum_next;
    wire last_word;
    wire [CNT_W-1:0] idx_next;
    // decoded events and derived values of this cycle
    wire start;
    wire take_word;
    wire image_ok;
    wire [ADDR_W-1:0] hdr_base;
    wire [ADDR_W-1:0] next_addr;
    wire [CNT_W-1:0] total_words;

    // byte address of dword idx of an image whose header sits at base
    function [ADDR_W-1:0] word_addr;
        input [ADDR_W-1:0] base;
        input [CNT_W-1:0] idx;
        begin
            word_addr = base + {{(ADDR_W-CNT_W-2){1'b0}}, idx, 2'b00};
        end
    endfunction

    // image is good only with version one and a zero sum
    function image_good;
        input [31:0] sum;
        input ver_ok;
        begin
            image_good = (sum == `MCUL_SUM_GOOD) && ver_ok;
        end
    endfunction

    // dword count from a byte size; bits below a dword are dropped
    function [CNT_W-1:0] bytes_to_words;
        input [31:0] bytes;
        begin
            bytes_to_words = bytes[CNT_W+1:2];
        end
    endfunction

    // low address bits must be clear for 16-byte alignment
    function is_aligned;
        input [63:0] addr;
        begin
            is_aligned = (addr[`MCUL_ALIGN_BITS-1:0] == {`MCUL_ALIGN_BITS{1'b0}});
        end
    endfunction

    // trigger decode; the written value is the update data address
    assign trig_hit = model_register_write && (msr_addr == `MCUL_TRIG_ADDR); // RULE7
    // alignment of the supplied data address
    assign aligned = is_aligned(msr_wdata); // RULE23
    // unsigned modulo-2^32 accumulation, carry out dropped
    assign sum_next = sum_q + mem_rdata; // RULE1 RULE3
    assign idx_next = idx_q + {{(CNT_W-1){1'b0}}, 1'b1};
    assign last_word = (idx_next == words_q); // RULE4
    // a trigger that starts a check this cycle
    assign start = (state_q == ST_IDLE) && trig_hit && aligned && !init_event; // RULE7
    // a returned dword that the check takes this cycle
    assign take_word = (state_q == ST_WAIT) && mem_valid && !init_event;
    // header start, 48 bytes before the supplied data address
    assign hdr_base = msr_wdata[ADDR_W-1:0] - `MCUL_DATA_OFS; // RULE9
    // address of the dword after the one just taken
    assign next_addr = word_addr(base_q, idx_next);
    // length taken from the total-size field
    assign total_words = bytes_to_words(mem_rdata); // RULE6
    // verdict of the running sum
    assign image_ok = image_good(sum_q, ver_ok_q); // RULE1 RULE22

    // next state
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (trig_hit && aligned) begin
                    state_d = ST_REQ;
                end
            end
            ST_REQ: begin
                state_d = ST_WAIT;
            end
            ST_WAIT: begin
                if (mem_valid) begin
                    state_d = last_word ? ST_END : ST_REQ;
                end
            end
            ST_END: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (init_event) begin
            state_d = ST_IDLE;
        end
    end

    // state register and handshake outputs
    always @(posedge clock) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
            mem_req_q <= 1'b0;
            busy_q <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            // one request per fetch state, so one word is outstanding at most
            mem_req_q <= (state_d == ST_REQ);
            // busy follows the next state, so it drops with the done pulse
            busy_q <= (state_d != ST_IDLE);
        end
    end

    // fetch address; index and base change at this same edge, so the
    // address is formed from their next values
    always @(posedge clock) begin
        if (!resetn) begin
            mem_addr_q <= `MCUL_RST_ADDR;
        end else if (ce) begin
            if (start) begin
                mem_addr_q <= word_addr(hdr_base, `MCUL_RST_IDX); // RULE9
            end else if (take_word && !last_word) begin
                mem_addr_q <= next_addr; // RULE4
            end
        end
    end

    // check setup; header lies 48 bytes before the data
    always @(posedge clock) begin
        if (!resetn) begin
            base_q <= `MCUL_RST_ADDR;
            data_addr_q <= `MCUL_RST_ADDR;
        end else if (ce && start) begin
            data_addr_q <= msr_wdata[ADDR_W-1:0];
            base_q <= hdr_base; // RULE9
        end
    end

    // running sum, word index and header fields
    always @(posedge clock) begin
        if (!resetn) begin
            idx_q <= `MCUL_RST_IDX;
            words_q <= `MCUL_DEFAULT_WORDS;
            sum_q <= `MCUL_RST_SUM;
            dsize_q <= `MCUL_RST_SUM;
            ver_ok_q <= 1'b0;
        end else if (ce) begin
            if (start) begin
                // a new check forgets the header of the last one
                idx_q <= `MCUL_RST_IDX;
                words_q <= `MCUL_DEFAULT_WORDS; // RULE5
                sum_q <= `MCUL_RST_SUM;
                dsize_q <= `MCUL_RST_SUM;
                ver_ok_q <= 1'b0;
            end else if (take_word) begin
                sum_q <= sum_next; // RULE1
                idx_q <= idx_next;
                if (idx_q == `MCUL_IDX_VERSION) begin
                    ver_ok_q <= (mem_rdata == `MCUL_HDR_VERSION); // RULE4
                end
                if (idx_q == `MCUL_IDX_DATA_SIZE) begin
                    dsize_q <= mem_rdata;
                end
                // total size in dwords, used only when data size was nonzero
                if (idx_q == `MCUL_IDX_TOTAL_SIZE && dsize_q != `MCUL_RST_SUM) begin
                    words_q <= total_words; // RULE6
                end
            end
        end
    end

    // check verdict and done pulse
    always @(posedge clock) begin
        if (!resetn) begin
            chk_done_q <= 1'b0;
            chk_pass_q <= 1'b0;
        end else if (ce) begin
            chk_done_q <= 1'b0;
            // a new trigger clears the last verdict
            if (trig_hit && state_q == ST_IDLE) begin
                chk_pass_q <= 1'b0;
            end
            // done pulse with verdict after the last word; an abort gives none
            if (state_q == ST_END && !init_event) begin
                chk_done_q <= 1'b1; // RULE22
                chk_pass_q <= image_ok; // RULE22 RULE1
            end
        end
    end

    // sticky error and collision flags; set and clear never share a cycle
    always @(posedge clock) begin
        if (!resetn) begin
            load_err_q <= 1'b0;
            collide_q <= 1'b0;
        end else if (ce) begin
            // a trigger while a check runs is refused
            if (trig_hit && state_q != ST_IDLE) begin
                collide_q <= 1'b1; // RULE19
            end
            // new trigger clears old status; a misaligned one sets the error
            if (trig_hit && state_q == ST_IDLE) begin
                collide_q <= 1'b0;
                load_err_q <= !aligned; // RULE23
            end
            // a failed check raises the error
            if (state_q == ST_END && !init_event && !image_ok) begin
                load_err_q <= 1'b1; // RULE23
            end
        end
    end

    // applied update; only hard reset clears it, soft init leaves it alone
    always @(posedge clock) begin
        if (!resetn) begin
            update_active_q <= 1'b0; // RULE14
            update_apply_q <= 1'b0;
            update_addr_q <= `MCUL_RST_ADDR; // RULE14
        end else if (ce) begin
            update_apply_q <= 1'b0;
            // a failed or aborted check falls through and keeps the old update
            if (state_q == ST_END && !init_event && image_ok) begin // RULE15 RULE23
                // same image again rewrites the same state
                update_active_q <= 1'b1; // RULE16
                update_apply_q <= 1'b1;
                update_addr_q <= data_addr_q; // RULE16
            end
        end
    end

endmodule

`default_nettype wire

// file: verification/mcul_loader_properties.sv
`timescale 1ns/100ps
`default_nettype none
module mcul_loader_props (
    // control inputs and the fetch and update address outputs
    input wire logic clock, resetn, ce, init_event, model_register_write,
    input wire logic [31:0] msr_addr,
    input wire logic [63:0] msr_wdata, mem_addr_q, update_addr_q,
    // status outputs
    input wire logic mem_req_q, busy_q, chk_done_q, chk_pass_q, load_err_q, collide_q,
    input wire logic update_active_q, update_apply_q
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // trigger write seen by the loader
    wire trig = ce && model_register_write && msr_addr == 32'h0000_0079;
    a_trig_start: assert property (
        trig && !busy_q && !init_event && msr_wdata[3:0] == 4'h0 |=>
        busy_q && mem_req_q && mem_addr_q == $past(msr_wdata) - 64'h0000_0000_0000_0030)
        else $error("aligned trigger did not start a fetch");
    a_misalign_err: assert property (
        trig && !busy_q && !init_event && msr_wdata[3:0] != 4'h0 |=> load_err_q && !busy_q)
        else $error("misaligned trigger not refused");
    a_busy_collide: assert property (trig && busy_q && !init_event |=> collide_q)
        else $error("trigger while busy not flagged");
    a_pass_apply: assert property (
        chk_done_q && chk_pass_q |-> update_apply_q && update_active_q && !load_err_q)
        else $error("passed check not applied");
    a_fail_keep: assert property (
        chk_done_q && !chk_pass_q |-> load_err_q && !update_apply_q)
        else $error("failed check applied");
    a_addr_held: assert property ($changed(update_addr_q) |-> update_apply_q)
        else $error("update address moved without apply");
    a_active_kept: assert property (update_active_q |=> update_active_q)
        else $error("loaded update dropped");
    a_reset_drops: assert property (
        disable iff (1'b0) !resetn |=> !update_active_q && !busy_q)
        else $error("hard reset kept the update");
    a_done_cause: assert property ($fell(busy_q) |-> chk_done_q || $past(init_event))
        else $error("check ended without done");
    a_req_single: assert property (mem_req_q |=> !mem_req_q)
        else $error("fetch request longer than one cycle");
    c_pass: cover property (chk_done_q && chk_pass_q);
    c_fail: cover property (chk_done_q && !chk_pass_q);
    c_collide: cover property (collide_q);
endmodule
bind mcul_loader mcul_loader_props u_props (.clock, .resetn, .ce, .init_event,
    .model_register_write, .msr_addr, .msr_wdata, .mem_addr_q, .update_addr_q, .mem_req_q,
    .busy_q, .chk_done_q, .chk_pass_q, .load_err_q, .collide_q, .update_active_q,
    .update_apply_q);
`default_nettype wire

// file: verification/mcul_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module mcul_mem_model (
    // fetch request
    input wire logic clock,
    input wire logic mem_req,
    input wire logic [63:0] mem_addr,
    input wire logic [1:0] slow,
    // returned dword
    output logic mem_valid,
    output logic [31:0] mem_rdata
);
    logic [31:0] img [0:511]; // image resident and mapped, one window
    initial begin
        mem_valid = 1'b0;
        mem_rdata = 32'h0000_0000;
    end
    // answer after slow extra cycles; data inverts once released
    always @(posedge clock) begin
        if (mem_req) begin
            repeat (slow) @(posedge clock);
            #1 mem_valid = 1'b1;
            mem_rdata = img[mem_addr[10:2]];
            @(posedge clock) #1 mem_valid = 1'b0;
            mem_rdata = ~mem_rdata;
        end
    end
endmodule
`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clock = 1'b0, resetn = 1'b0, ce = 1'b1, init_event = 1'b0, act = 1'b0;
    logic model_register_write = 1'b0;
    logic [31:0] msr_addr = 32'h0000_0000, seed = 32'h0000_005d;
    logic [63:0] msr_wdata = 64'h0000_0000_0000_0000, exp_addr = 64'h0000_0000_0000_0000;
    logic [1:0] slow = 2'h0;
    wire mem_req_q, mem_valid, busy_q, chk_done_q, chk_pass_q, load_err_q, collide_q;
    wire update_active_q, update_apply_q;
    wire [63:0] mem_addr_q, update_addr_q;
    wire [31:0] mem_rdata;
    int error_cnt = 0, check_count = 0, nreq = 0;
    mcul_loader dut (.clock, .resetn, .ce, .init_event, .model_register_write, .msr_addr,
        .msr_wdata, .mem_req_q, .mem_addr_q, .mem_valid, .mem_rdata, .busy_q, .chk_done_q,
        .chk_pass_q, .load_err_q, .collide_q, .update_active_q, .update_apply_q, .update_addr_q);
    mcul_mem_model mem (.clock, .mem_req(mem_req_q), .mem_addr(mem_addr_q), .slow, .mem_valid,
        .mem_rdata);
    initial forever #2 clock = ~clock;
    // count fetches of all checks; a run subtracts the count it started with
    always @(posedge clock) if (mem_req_q === 1'b1) nreq <= nreq + 1;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(string name, logic [63:0] seen, logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // one-cycle model register write
    task automatic wr(logic [31:0] a, logic [63:0] d);
        @(posedge clock) #1 model_register_write = 1'b1;
        msr_addr = a;
        msr_wdata = d;
        @(posedge clock) #1 model_register_write = 1'b0;
    endtask
    // random image summing to zero unless spoiled
    task automatic build(int words, bit zero_size, bit bad);
        logic [31:0] sum;
        sum = 32'h0000_0000;
        for (int i = 0; i < 512; i++) mem.img[i] = rnd();
        mem.img[0] = 32'h0000_0001;
        mem.img[8] = zero_size ? 32'h0000_0000 : (rnd() | 32'h0000_0001);
        mem.img[9] = 32'(words * 4);
        mem.img[3] = 32'h8000_0000;
        for (int i = 2; i < words; i++) sum += mem.img[i];
        mem.img[1] = -(sum + 32'h0000_0001) + 32'(bad);
    endtask
    // one load and its outcome
    task automatic run(bit zero_size, bit bad, logic [63:0] a);
        int words;
        int n;
        int n0;
        words = zero_size ? 512 : 256;
        build(words, zero_size, bad);
        slow = 2'(rnd() % 3);
        n0 = nreq;
        wr(32'h0000_0079, a);
        for (n = 0; n < 4000 && chk_done_q !== 1'b1; n++) @(posedge clock) #1;
        if (n == 4000) begin
            error_cnt++;
            final_report();
        end
        act = act | !bad;
        if (!bad) exp_addr = a;
        chk("pass", chk_pass_q, !bad);
        chk("error", load_err_q, bad);
        chk("words", nreq - n0, words);
        chk("active", update_active_q, act);
        chk("address", update_addr_q, exp_addr);
    endtask
    initial begin
        repeat (20) @(posedge clock);
        #1 resetn = 1'b1;
        chk("active", update_active_q, 1'b0);
        wr(32'h0000_007a, 64'h0000_0000_0000_1030);
        chk("busy", busy_q, 1'b0);
        for (int i = 0; i < 6; i++) begin
            run(i[0], i == 1 || i == 4, {rnd(), 32'h0000_1030});
        end
        wr(32'h0000_0079, 64'h0000_0000_0000_1038);
        chk("misalign", load_err_q, 1'b1);
        chk("address", update_addr_q, exp_addr);
        build(256, 1'b0, 1'b0);
        wr(32'h0000_0079, 64'h0000_0000_0000_1030);
        wr(32'h0000_0079, 64'h0000_0000_0000_1030);
        chk("collide", collide_q, 1'b1);
        @(posedge clock) #1 init_event = 1'b1;
        @(posedge clock) #1 init_event = 1'b0;
        chk("init", update_active_q, 1'b1);
        resetn = 1'b0;
        repeat (3) @(posedge clock);
        #1 chk("reset", update_active_q, 1'b0);
        resetn = 1'b1;
        repeat (2) @(posedge clock);
        #1 chk("busy", busy_q, 1'b0);
        chk("active", update_active_q, 1'b0);
        act = 1'b0;
        exp_addr = 64'h0000_0000_0000_0000;
        run(1'b1, 1'b0, {rnd(), 32'h0000_2030});
        final_report();
    end
endmodule
`default_nettype wire
